// file: hw/mcd_pkg.sv
// constants of the motor control diagnostic and run register bank
// assumes a serial link engine that hands over decoded register accesses
package mcd_pkg;
  localparam logic [4:0] MCD_REG_NVM = 5'h1C;
  localparam logic [4:0] MCD_REG_MASK = 5'h1D;
  localparam logic [4:0] MCD_REG_FAULT_OUTPUT_PIN = 5'h1E;
  localparam logic [4:0] MCD_REG_RUN = 5'h1F;
  localparam int MCD_SAVE_BIT = 9;
  localparam int MCD_COUNT_W = 10;
  localparam logic [9:0] MCD_COUNT_MAX = 10'h3FF;
  // masked fault flags sit at bits 9:3 of the mask and diagnostic words
  localparam int MCD_FLAG_LSB = 3;
  localparam int MCD_DSEL_HI_LSB = 2;
  // run word fields
  localparam int MCD_RUN_DSEL_LSB = 8;
  localparam int MCD_RUN_KEEP = 7;
  localparam int MCD_RUN_SBY_IGN = 6;
  localparam int MCD_RUN_STYLE = 5;
  localparam int MCD_RUN_ACTION = 4;
  localparam int MCD_RUN_RESTART = 3;
  localparam int MCD_RUN_BRAKE = 2;
  localparam int MCD_RUN_DIR = 1;
  localparam int MCD_RUN_RUN = 0;
  localparam logic [9:0] MCD_RUN_RESET = 10'h092;
  localparam logic [6:0] MCD_MASK_RESET = 7'h00;
  localparam logic [2:0] MCD_DSEL_HI_RESET = 3'h0;
  // masked fault indices
  localparam int MCD_F_HOC = 2;
  localparam int MCD_F_LOS = 4;
  // nonvolatile image: config words, then mask, then run word
  localparam logic [4:0] MCD_CFG_WORDS = 5'h16;
  localparam logic [4:0] MCD_LAST_WORD = 5'h17;
  localparam int MCD_DSEL_SRC = 21;
  localparam int MCD_SRC_ANY = 0;
  localparam int MCD_SRC_LOS = 1;
  localparam int MCD_SRC_GDF = 17;
  localparam int MCD_SRC_HOC = 19;
  typedef enum logic [1:0] {MCD_ST_IDLE, MCD_ST_LOAD, MCD_ST_WRITE} mcd_nvm_state_type;
endpackage

// file: hw/mcd_nvm_if.sv
// handshake between the register bank and the nonvolatile store sequencer
// assumes both ends share ref_clk
`timescale 1ns/1ps
interface mcd_nvm_if;
  logic start;
  logic busy;
  logic done;
  logic [9:0] mask_word;
  logic [9:0] run_word;
  modport ctrl (output start, output mask_word, output run_word, input busy, input done);
  modport store (input start, input mask_word, input run_word, output busy, output done);
endinterface

// file: hw/mcd_nvm_store.sv
// copies the configuration image word by word to nonvolatile storage
// assumes the storage accepts a word when nvm_wr_ready is high with nvm_wr_req
`timescale 1ns/1ps
module mcd_nvm_store
  import mcd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  mcd_nvm_if.store ctl,
  output logic [4:0] cfg_addr,
  input wire logic [15:0] cfg_data,
  output logic nvm_wr_req,
  output logic [4:0] nvm_wr_addr,
  output logic [15:0] nvm_wr_data,
  input wire logic nvm_wr_ready
);
  mcd_nvm_state_type st_q, st_d;
  logic [4:0] idx_q, idx_d;
  logic [15:0] data_q, data_d;
  logic done_q, done_d;

  always_comb begin
    st_d = st_q;
    idx_d = idx_q;
    data_d = data_q;
    done_d = 1'b0;
    case (st_q)
      MCD_ST_IDLE: begin
        if (ctl.start) begin
          idx_d = 5'h00;
          st_d = MCD_ST_LOAD;
        end
      end
      MCD_ST_LOAD: begin
        if (idx_q < MCD_CFG_WORDS) begin
          data_d = cfg_data;
        end else if (idx_q == MCD_CFG_WORDS) begin
          data_d = {6'h00, ctl.mask_word};
        end else begin
          data_d = {6'h00, ctl.run_word};
        end
        st_d = MCD_ST_WRITE;
      end
      MCD_ST_WRITE: begin
        if (nvm_wr_ready) begin
          if (idx_q == MCD_LAST_WORD) begin
            done_d = 1'b1;
            st_d = MCD_ST_IDLE;
          end else begin
            idx_d = idx_q + 5'h01;
            st_d = MCD_ST_LOAD;
          end
        end
      end
      default: st_d = MCD_ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q <= MCD_ST_IDLE;
      idx_q <= 5'h00;
      data_q <= 16'h0000;
      done_q <= 1'b0;
    end else if (clk_en) begin
      st_q <= st_d;
      idx_q <= idx_d;
      data_q <= data_d;
      done_q <= done_d;
    end
  end

  assign cfg_addr = idx_q;
  assign nvm_wr_req = (st_q == MCD_ST_WRITE);
  assign nvm_wr_addr = idx_q;
  assign nvm_wr_data = data_q;
  assign ctl.busy = (st_q != MCD_ST_IDLE) || done_q;
  assign ctl.done = done_q;
endmodule // mcd_nvm_store

// file: hw/mcd_fault_output_pin_mux.sv
// routes one of the selectable sources to the open-drain fault pin
// assumes all sources are on ref_clk and active high
`timescale 1ns/1ps
module mcd_fault_output_pin_mux
  import mcd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [4:0] sel,
  input wire logic [MCD_DSEL_SRC-1:0] src,
  output logic pin_o,
  output logic pin_oe_n
);
  logic oe_n_q, oe_n_d;

  always_comb begin
    // reserved codes leave the pin released
    oe_n_d = 1'b1;
    if (sel < 5'(MCD_DSEL_SRC)) begin
      oe_n_d = ~src[sel];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      oe_n_q <= 1'b1;
    end else if (clk_en) begin
      oe_n_q <= oe_n_d;
    end
  end

  assign pin_o = 1'b0;
  assign pin_oe_n = oe_n_q;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n || !clk_en);
  chk_pin_follows_sel: assert property (sel == 5'h00 && src[0] |=> !pin_oe_n)
    else $error("fault pin not pulled low for selected fault");
  chk_reserved_code: assert property (sel >= 5'h15 |=> pin_oe_n)
    else $error("reserved select code drove the fault pin");
endmodule // mcd_fault_output_pin_mux

// file: hw/mcd_regs.sv
// save control, fault mask, diagnostic and run registers of the motor driver
// assumes decoded register accesses from the serial link on ref_clk
//
// Contract
// - save falling edge stores image when stopped, unlocked
// - each store bumps write counter by one
// - wear flag sets on the 1024th store, forever
// - mask bit one disables that fault
// - diagnostic read shows fault bits 15 to 3
// - every read carries six fault flags on top
// - fault pin select split across two registers
// - fault pin low while selected fault present
// - select codes route the listed pin sources
// - run register field layout bits 9 to 0
// - latch keep zero clears status, blocks restart
// - standby follows reset pin unless ignored
// - startup style picks ramp or dc align
// - fault action keeps driving or kills stage
// - auto restart after trips when run, no brake
// - brake only with run, low sides on
// - brake bit leaves startup braking alone
// - direction is bit xnor pin
// - run bit starts or stops excitation
`timescale 1ns/1ps
module mcd_regs
  import mcd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic motor_stopped,
  input wire logic unlocked_mode,
  input wire logic [6:0] masked_fault_evt,
  input wire logic [3:0] critical_fault_evt,
  input wire logic [MCD_DSEL_SRC-1:0] aux_fault_output_pin_src,
  input wire logic startup_brake,
  input wire logic dir_pin,
  input wire logic chip_reset_n,
  output logic [4:0] cfg_addr,
  input wire logic [15:0] cfg_data,
  output logic nvm_wr_req,
  output logic [4:0] nvm_wr_addr,
  output logic [15:0] nvm_wr_data,
  input wire logic nvm_wr_ready,
  output logic fault_output_pin_o,
  output logic fault_output_pin_oe_n,
  output logic motor_run_en,
  output logic lowside_brake_on,
  output logic rotate_forward,
  output logic startup_dc_align,
  output logic gate_driver_standby,
  output logic power_stage_off,
  output logic restart_req,
  output logic coast_stop
);
  ////////////////////////////////////////////////////////////////////////////
  mcd_nvm_if nvm ();

  logic dir_s1_q, dir_s2_q, rstp_s1_q, rstp_s2_q;
  logic nvm_save_trigger_q, nvm_save_trigger_d;
  logic start_q, start_d;
  logic [MCD_COUNT_W-1:0] nvm_write_count_q, nvm_write_count_d;
  logic storage_wear_flag_q, storage_wear_flag_d;
  logic [6:0] mask_q, mask_d;
  logic [2:0] dsel_hi_q, dsel_hi_d;
  logic [9:0] run_q, run_d;
  logic [6:0] evt_q, evt_d;
  logic [3:0] crit_q, crit_d;
  logic trip_prev_q, trip_d;
  logic [15:0] rdata_q, rdata_d;
  logic [5:0] ctl_q, ctl_d;
  logic restart_q, restart_d;
  logic any_fault_flag;
  logic [12:0] fault_output_pin_vec;
  logic [4:0] fault_output_select;
  logic [MCD_DSEL_SRC-1:0] fault_output_pin_src;
  logic wr_nvm, save_fall, save_ok;

  ////////////////////////////////////////////////////////////////////////////
  // pins from outside the clock domain
  // the reset pin sync starts at its idle high level, else standby pulses once after reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dir_s1_q <= 1'b0;
      dir_s2_q <= 1'b0;
      rstp_s1_q <= 1'b1;
      rstp_s2_q <= 1'b1;
    end else if (clk_en) begin
      dir_s1_q <= dir_pin;
      dir_s2_q <= dir_s1_q;
      rstp_s1_q <= chip_reset_n;
      rstp_s2_q <= rstp_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fault flags; upper six are any, logic supply low, memory, watchdog, soft oc, wear
  assign any_fault_flag = |{crit_q, storage_wear_flag_q, evt_q};
  assign fault_output_pin_vec = {any_fault_flag, crit_q[3:0], storage_wear_flag_q, evt_q};
  assign fault_output_select = {dsel_hi_q, run_q[MCD_RUN_DSEL_LSB+1:MCD_RUN_DSEL_LSB]};

  always_comb begin
    fault_output_pin_src = aux_fault_output_pin_src;
    fault_output_pin_src[MCD_SRC_ANY] = any_fault_flag;
    fault_output_pin_src[MCD_SRC_LOS] = evt_q[MCD_F_LOS];
    fault_output_pin_src[MCD_SRC_GDF] = evt_q[3];
    fault_output_pin_src[MCD_SRC_HOC] = evt_q[MCD_F_HOC];
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes, save trigger and write counter
  assign wr_nvm = reg_wr && (reg_addr == MCD_REG_NVM);
  assign save_fall = wr_nvm && nvm_save_trigger_q && !reg_wdata[MCD_SAVE_BIT];
  // a save while running, locked or already storing is dropped outright
  assign save_ok = motor_stopped && unlocked_mode && !nvm.busy && !start_q;

  always_comb begin
    nvm_save_trigger_d = nvm_save_trigger_q;
    mask_d = mask_q;
    dsel_hi_d = dsel_hi_q;
    run_d = run_q;
    start_d = save_fall && save_ok;
    nvm_write_count_d = nvm_write_count_q;
    storage_wear_flag_d = storage_wear_flag_q;
    if (wr_nvm) begin
      nvm_save_trigger_d = reg_wdata[MCD_SAVE_BIT];
    end
    if (reg_wr && reg_addr == MCD_REG_MASK) begin
      mask_d = reg_wdata[MCD_FLAG_LSB+6:MCD_FLAG_LSB];
    end
    if (reg_wr && reg_addr == MCD_REG_FAULT_OUTPUT_PIN) begin
      dsel_hi_d = reg_wdata[MCD_DSEL_HI_LSB+2:MCD_DSEL_HI_LSB];
    end
    if (reg_wr && reg_addr == MCD_REG_RUN) begin
      run_d = reg_wdata[9:0];
    end
    if (nvm.done) begin
      nvm_write_count_d = nvm_write_count_q + 10'h001;
      if (nvm_write_count_q == MCD_COUNT_MAX) begin
        storage_wear_flag_d = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      nvm_save_trigger_q <= 1'b0;
      mask_q <= MCD_MASK_RESET;
      dsel_hi_q <= MCD_DSEL_HI_RESET;
      run_q <= MCD_RUN_RESET;
      start_q <= 1'b0;
      nvm_write_count_q <= 10'h000;
      storage_wear_flag_q <= 1'b0;
    end else if (clk_en) begin
      nvm_save_trigger_q <= nvm_save_trigger_d;
      mask_q <= mask_d;
      dsel_hi_q <= dsel_hi_d;
      run_q <= run_d;
      start_q <= start_d;
      nvm_write_count_q <= nvm_write_count_d;
      storage_wear_flag_q <= storage_wear_flag_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fault capture; a new event in the clearing cycle still sets its flag
  always_comb begin
    evt_d = masked_fault_evt & ~mask_q;
    crit_d = critical_fault_evt;
    if (run_q[MCD_RUN_KEEP]) begin
      evt_d = evt_d | evt_q;
      crit_d = crit_d | crit_q;
    end
    trip_d = evt_d[MCD_F_LOS] | evt_d[MCD_F_HOC] | critical_fault_evt[0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // motor control outputs
  always_comb begin
    ctl_d[0] = run_q[MCD_RUN_RUN];
    // startup braking stays with the sequencer whatever the brake bit says
    ctl_d[1] = startup_brake | (run_q[MCD_RUN_RUN] & run_q[MCD_RUN_BRAKE]);
    ctl_d[2] = ~(run_q[MCD_RUN_DIR] ^ dir_s2_q);
    ctl_d[3] = run_q[MCD_RUN_STYLE];
    ctl_d[4] = ~run_q[MCD_RUN_SBY_IGN] & ~rstp_s2_q;
    ctl_d[5] = run_q[MCD_RUN_ACTION] & (|{crit_q, evt_q});
    restart_d = trip_d && !trip_prev_q && run_q[MCD_RUN_RESTART] && run_q[MCD_RUN_RUN] &&
                !run_q[MCD_RUN_BRAKE] && run_q[MCD_RUN_KEEP];
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      evt_q <= 7'h00;
      crit_q <= 4'h0;
      trip_prev_q <= 1'b0;
      ctl_q <= 6'h00;
      restart_q <= 1'b0;
    end else if (clk_en) begin
      evt_q <= evt_d;
      crit_q <= crit_d;
      trip_prev_q <= trip_d;
      ctl_q <= ctl_d;
      restart_q <= restart_d;
    end
  end

  assign motor_run_en = ctl_q[0];
  assign lowside_brake_on = ctl_q[1];
  assign rotate_forward = ctl_q[2];
  assign startup_dc_align = ctl_q[3];
  assign gate_driver_standby = ctl_q[4];
  assign power_stage_off = ctl_q[5];
  assign restart_req = restart_q;
  assign coast_stop = evt_q[MCD_F_LOS] & ~run_q[MCD_RUN_RESTART];

  ////////////////////////////////////////////////////////////////////////////
  // read path; unmapped numbers return the flags over zero settings
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      rdata_d = {fault_output_pin_vec[12:7], 10'h000};
      case (reg_addr)
        MCD_REG_NVM: rdata_d[9:0] = nvm_write_count_q;
        MCD_REG_MASK: rdata_d[9:0] = {mask_q, 3'h0};
        MCD_REG_FAULT_OUTPUT_PIN: rdata_d[9:0] = {fault_output_pin_vec[6:0], 3'h0};
        MCD_REG_RUN: rdata_d[9:0] = run_q;
        default: rdata_d[9:0] = 10'h000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata_q <= 16'h0000;
    end else if (clk_en) begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  assign nvm.start = start_q;
  assign nvm.mask_word = {mask_q, 3'h0};
  assign nvm.run_word = run_q;

  mcd_nvm_store u_store (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .ctl(nvm),
    .cfg_addr(cfg_addr),
    .cfg_data(cfg_data),
    .nvm_wr_req(nvm_wr_req),
    .nvm_wr_addr(nvm_wr_addr),
    .nvm_wr_data(nvm_wr_data),
    .nvm_wr_ready(nvm_wr_ready)
  );

  mcd_fault_output_pin_mux u_fault_output_pin (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .sel(fault_output_select),
    .src(fault_output_pin_src),
    .pin_o(fault_output_pin_o),
    .pin_oe_n(fault_output_pin_oe_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n || !clk_en);

  chk_save_starts: assert property (save_fall && save_ok |=> nvm.start ##1 nvm.busy)
    else $error("accepted save did not start a store");
  chk_count_step: assert property (nvm.done |=> nvm_write_count_q == $past(nvm_write_count_q) + 10'h001)
    else $error("write counter did not advance by one");
  chk_wear_sticky: assert property (storage_wear_flag_q |=> storage_wear_flag_q)
    else $error("wear flag cleared");
  chk_wear_set: assert property (nvm.done && nvm_write_count_q == 10'h3FF |=> storage_wear_flag_q)
    else $error("wear flag not set after counter limit");
  chk_mask_blocks: assert property (!run_q[MCD_RUN_KEEP] && mask_q == 7'h7F ##1 mask_q == 7'h7F |-> evt_q == 7'h00)
    else $error("masked fault reached the diagnostic flags");
  chk_fault_output_pin_read: assert property (reg_rd && reg_addr == MCD_REG_FAULT_OUTPUT_PIN |=> reg_rdata == {$past(fault_output_pin_vec), 3'h0})
    else $error("diagnostic read layout wrong");
  chk_upper_flags: assert property (reg_rd |=> reg_rdata[15:10] == $past(fault_output_pin_vec[12:7]))
    else $error("upper fault flags missing from read");
  chk_refused_save: assert property (save_fall && !save_ok |=> !nvm.start)
    else $error("refused save started a store");
  chk_brake_needs_run: assert property (lowside_brake_on && !$past(startup_brake) |-> $past(run_q[MCD_RUN_RUN]))
    else $error("brake applied without run");
  chk_direction: assert property (##1 rotate_forward == ~($past(run_q[MCD_RUN_DIR]) ^ $past(dir_s2_q)))
    else $error("direction does not follow bit and pin");
  chk_keep_blocks_restart: assert property (!run_q[MCD_RUN_KEEP] |=> !restart_req)
    else $error("restart raised while fault latch is off");

  cov_store_done: cover property (nvm.start ##[1:200] nvm.done);
  cov_wear_set: cover property ($rose(storage_wear_flag_q));
  cov_restart: cover property (restart_req);
  cov_refused: cover property (save_fall && !save_ok);
endmodule // mcd_regs

// file: test/mcd_nvm_model.sv
// behavioural nonvolatile store and configuration word source
// assumes the bank offers one word at a time with a level request
`timescale 1ns/1ps
module mcd_nvm_model (
  input wire logic ref_clk,
  input wire logic slow,
  input wire logic [4:0] cfg_addr,
  output logic [15:0] cfg_data,
  input wire logic nvm_wr_req,
  input wire logic [4:0] nvm_wr_addr,
  input wire logic [15:0] nvm_wr_data,
  output logic nvm_wr_ready,
  output int words,
  output logic [15:0] img [0:23]
);
  logic [1:0] stall_q = 2'h0;
  initial begin
    nvm_wr_ready = 1'b0;
    words = 0;
  end
  // pattern keeps every word index distinguishable in the stored image
  assign cfg_data = 16'hA500 | {11'h000, cfg_addr};
  //////////////////////////////////////////////////////////////////////
  // slow mode answers only every third cycle, like a busy array
  always @(posedge ref_clk) begin
    if (nvm_wr_req && nvm_wr_ready) begin
      img[nvm_wr_addr] <= nvm_wr_data;
      words <= words + 1;
    end
    stall_q <= (stall_q == 2'h2) ? 2'h0 : stall_q + 2'h1;
    nvm_wr_ready <= !slow || (stall_q == 2'h2);
  end
endmodule // mcd_nvm_model

// file: test/tb.sv
// self-checking bench for the diagnostic and run register bank
// assumes mcd_regs beside the behavioural store model mcd_nvm_model
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb
  import mcd_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic motor_stopped = 1'b0;
  logic unlocked_mode = 1'b0;
  logic [6:0] masked_fault_evt = 7'h00;
  logic [3:0] critical_fault_evt = 4'h0;
  logic [MCD_DSEL_SRC-1:0] aux_fault_output_pin_src = '0;
  logic startup_brake = 1'b0;
  logic dir_pin = 1'b0;
  logic chip_reset_n = 1'b1;
  logic slow = 1'b0;
  logic [15:0] reg_rdata, cfg_data, nvm_wr_data;
  logic [4:0] cfg_addr, nvm_wr_addr;
  logic nvm_wr_req, nvm_wr_ready, pin_o, pin_oe_n, run_en, brake_on, fwd, dc_align;
  logic standby, stage_off, restart, coast;
  int words;
  logic [15:0] img [0:23];
  logic [31:0] exp_q [$];
  logic [31:0] e;
  logic rd_seen = 1'b0;
  int failures = 0;
  int compares = 0;
  // the pin has a pull-up, so a released pin reads high
  wire fault_pin = pin_oe_n ? 1'b1 : pin_o;

  always #20 ref_clk = ~ref_clk;

  mcd_regs DUT (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .motor_stopped(motor_stopped),
    .unlocked_mode(unlocked_mode), .masked_fault_evt(masked_fault_evt), .critical_fault_evt(critical_fault_evt),
    .aux_fault_output_pin_src(aux_fault_output_pin_src), .startup_brake(startup_brake), .dir_pin(dir_pin), .chip_reset_n(chip_reset_n),
    .cfg_addr(cfg_addr), .cfg_data(cfg_data), .nvm_wr_req(nvm_wr_req), .nvm_wr_addr(nvm_wr_addr),
    .nvm_wr_data(nvm_wr_data), .nvm_wr_ready(nvm_wr_ready), .fault_output_pin_o(pin_o),
    .fault_output_pin_oe_n(pin_oe_n), .motor_run_en(run_en), .lowside_brake_on(brake_on),
    .rotate_forward(fwd), .startup_dc_align(dc_align), .gate_driver_standby(standby),
    .power_stage_off(stage_off), .restart_req(restart), .coast_stop(coast));

  mcd_nvm_model store_model (.ref_clk(ref_clk), .slow(slow), .cfg_addr(cfg_addr), .cfg_data(cfg_data),
    .nvm_wr_req(nvm_wr_req), .nvm_wr_addr(nvm_wr_addr), .nvm_wr_data(nvm_wr_data),
    .nvm_wr_ready(nvm_wr_ready), .words(words), .img(img));

  ////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    if (failures == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // expectation goes with a mask so that unrelated flag bits can be ignored
  task automatic rd(input logic [4:0] a, input logic [15:0] x, input logic [15:0] m);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back({m, x});
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask

  task automatic store(input int n);
    int k;
    wr(MCD_REG_NVM, 16'h0200);
    wr(MCD_REG_NVM, 16'h0000);
    for (k = 0; k < 400 && words < n; k++) @(posedge ref_clk);
    tick(3);
    `CHK("nvm_words", n, words)
  endtask

  always @(posedge ref_clk) begin
    if (rd_seen) begin
      e = exp_q.pop_front();
      `CHK("reg_rdata", e[15:0], reg_rdata & e[31:16])
    end
    rd_seen <= reg_rd;
  end

  initial begin
    tick(90000);
    failures++;
    finish_test;
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] rw;
    logic [6:0] m;
    logic [2:0] hi;
    logic [4:0] code;
    logic xp;
    int i, n;
    void'($urandom(16));
    tick(6);
    rst_n <= 1'b1;
    rd(MCD_REG_NVM, 16'h0000, 16'hFFFF);
    rd(MCD_REG_MASK, 16'h0000, 16'hFFFF);
    rd(MCD_REG_FAULT_OUTPUT_PIN, 16'h0000, 16'hFFFF);
    rd(MCD_REG_RUN, 16'h0092, 16'hFFFF);
    rd(5'h03, 16'h0000, 16'hFFFF);
    `CHK("fault_pin", 1'b1, fault_pin)
    `CHK("run_en", 1'b0, run_en)
    wr(MCD_REG_MASK, 16'hFFFF);
    rd(MCD_REG_MASK, 16'h03F8, 16'hFFFF);
    // random run words, select codes and pins, reserved codes included
    for (i = 0; i < 12; i++) begin
      rw = 16'($urandom);
      hi = 3'($urandom);
      dir_pin <= rw[12];
      startup_brake <= rw[13];
      chip_reset_n <= rw[14];
      aux_fault_output_pin_src <= MCD_DSEL_SRC'($urandom);
      wr(MCD_REG_FAULT_OUTPUT_PIN, {11'h000, hi, 2'h0});
      wr(MCD_REG_RUN, rw & 16'h03FF);
      tick(5);
      code = {hi, rw[9:8]};
      xp = (code > 20 || code == 0 || code == 1 || code == 17 || code == 19) ? 1'b1 : !aux_fault_output_pin_src[code];
      `CHK("run_en", rw[0], run_en)
      `CHK("brake_on", (rw[0] & rw[2]) | rw[13], brake_on)
      `CHK("fwd", rw[1] ~^ rw[12], fwd)
      `CHK("dc_align", rw[5], dc_align)
      `CHK("standby", !rw[6] & !rw[14], standby)
      `CHK("fault_pin", xp, fault_pin)
      rd(MCD_REG_RUN, rw & 16'h03FF, 16'hFFFF);
      rd(MCD_REG_FAULT_OUTPUT_PIN, 16'h0000, 16'hFFFF);
    end
    chip_reset_n <= 1'b1;
    startup_brake <= 1'b0;
    wr(MCD_REG_FAULT_OUTPUT_PIN, 16'h0000);
    wr(MCD_REG_MASK, 16'h0000);
    wr(MCD_REG_RUN, 16'h0012);
    for (i = 0; i < 7; i++) begin
      masked_fault_evt <= 7'(1 << i);
      tick(3);
      rd(MCD_REG_FAULT_OUTPUT_PIN, 16'h8000 | 16'(8 << i), 16'hFFFF);
      `CHK("fault_pin", 1'b0, fault_pin)
    end
    masked_fault_evt <= 7'h00;
    tick(3);
    rd(MCD_REG_FAULT_OUTPUT_PIN, 16'h0000, 16'hFFFF);
    wr(MCD_REG_MASK, 16'h0080);
    masked_fault_evt <= 7'h10;
    tick(3);
    rd(MCD_REG_FAULT_OUTPUT_PIN, 16'h0000, 16'hFFFF);
    `CHK("fault_pin", 1'b1, fault_pin)
    wr(MCD_REG_MASK, 16'h0000);
    wr(MCD_REG_RUN, 16'h0092);
    tick(3);
    `CHK("stage_off", 1'b1, stage_off)
    `CHK("coast", 1'b1, coast)
    masked_fault_evt <= 7'h00;
    tick(3);
    rd(MCD_REG_FAULT_OUTPUT_PIN, 16'h8080, 16'hFFFF);
    rd(MCD_REG_RUN, 16'h8092, 16'hFFFF);
    wr(MCD_REG_RUN, 16'h000B);
    wr(MCD_REG_RUN, 16'h008B);
    masked_fault_evt <= 7'h04;
    n = 0;
    for (i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      n += (restart === 1'b1) ? 1 : 0;
    end
    `CHK("restart_pulses", 1, n)
    `CHK("stage_off", 1'b0, stage_off)
    masked_fault_evt <= 7'h14;
    tick(3);
    `CHK("coast", 1'b0, coast)
    wr(MCD_REG_RUN, 16'h000B);
    masked_fault_evt <= 7'h00;
    critical_fault_evt <= 4'h1;
    tick(3);
    rd(MCD_REG_NVM, 16'h8800, 16'hFC00);
    critical_fault_evt <= 4'h0;
    unlocked_mode <= 1'b1;
    slow <= 1'b1;
    m = 7'($urandom);
    wr(MCD_REG_MASK, {6'h00, m, 3'h0});
    wr(MCD_REG_RUN, 16'h0092);
    store(0);
    motor_stopped <= 1'b1;
    unlocked_mode <= 1'b0;
    store(0);
    unlocked_mode <= 1'b1;
    store(24);
    rd(MCD_REG_NVM, 16'h0001, 16'h03FF);
    for (i = 0; i < 22; i++) `CHK("img", 16'hA500 | 16'(i), img[i])
    `CHK("img_mask", {6'h00, m, 3'h0}, img[22])
    `CHK("img_run", 16'h0092, img[23])
    // fast answers keep the 1024 stores inside the run budget
    slow <= 1'b0;
    for (i = 2; i < 1024; i++) store(24 * i);
    rd(MCD_REG_NVM, 16'h03FF, 16'h03FF);
    rd(MCD_REG_FAULT_OUTPUT_PIN, 16'h0000, 16'h0400);
    store(24 * 1024);
    rd(MCD_REG_FAULT_OUTPUT_PIN, 16'h0400, 16'h0400);
    wr(MCD_REG_RUN, 16'h0012);
    rd(MCD_REG_NVM, 16'h0400, 16'h07FF);
    // a frozen bank ignores a write and keeps its outputs
    clk_en <= 1'b0;
    wr(MCD_REG_RUN, 16'h0093);
    clk_en <= 1'b1;
    tick(2);
    `CHK("run_en", 1'b0, run_en)
    rd(MCD_REG_RUN, 16'h0012, 16'h03FF);
    // let the monitor take the last read before the verdict
    tick(2);
    `CHK("pending_reads", 0, exp_q.size())
    finish_test;
  end
endmodule // tb
